// file: inc/plt_line_if.sv
/*
 Link between the register side and the line pattern generator.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface plt_line_if;
	logic enable;
	logic [1:0] select;
	logic gap_long;
	logic seq_done;
	logic tx_level;
	logic tx_active;
	modport ctl (output enable, output select, output gap_long, input seq_done, input tx_level, input tx_active);
	modport gen (input enable, input select, input gap_long, output seq_done, output tx_level, output tx_active);
endinterface

// file: inc/plt_pkg.sv
/*
 Constants for the line-test and packet self-test extension block.
 Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
*/
package plt_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_TENMB_IDX = 8'h1A;
	localparam logic [7:0] REG_EXT_IDX = 8'h1B;
	localparam logic [7:0] REG_IRQ_STAT_IDX = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK_IDX = 8'h21;
	// Field positions
	localparam int F_CNT_LSB = 8;
	localparam int F_CONT = 5;
	localparam int F_PATEN = 4;
	localparam int F_GAP = 2;
	localparam int F_SEL_LSB = 0;
	localparam int F_JAB = 0;
	// Reset values and the count ceiling
	localparam logic [15:0] EXT_RESET = 16'h0000;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	// Interrupt status bits
	localparam int EV_ERR = 0;
	localparam int EV_SAT = 1;
	localparam int EV_SEQ = 2;
	localparam int NEV = 3;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int GAP10_NS = 10000;
	localparam int GAP15_NS = 15000;
	localparam int HALF_BIT_NS = 50;
	localparam int NLP_NS = 100;
	localparam logic [11:0] GAP10_CYC = 12'(GAP10_NS * CLK_MHZ / 1000);
	localparam logic [11:0] GAP15_CYC = 12'(GAP15_NS * CLK_MHZ / 1000);
	localparam logic [11:0] HALF_CYC = 12'(HALF_BIT_NS * CLK_MHZ / 1000);
	localparam logic [11:0] NLP_CYC = 12'((NLP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [6:0] DATA_BITS = 7'h40;
	localparam logic [6:0] END_ZERO_HALVES = 7'h04;
	localparam logic [6:0] END_ONE_HALVES = 7'h06;
	localparam logic [6:0] LFSR_SEED = 7'h7F;
	// Pattern select codes
	typedef enum logic [1:0] {PAT_END_ZERO = 2'h0, PAT_END_ONE = 2'h1, PAT_NLP = 2'h2, PAT_TONE = 2'h3} plt_pat_t;
	// Generator states, Gray along the data path
	typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_DATA = 3'h1, ST_EOP = 3'h3, ST_GAP = 3'h2,
		ST_NLP = 3'h6, ST_TONE = 3'h7} plt_state_t;
endpackage

// file: rtl/plt_line_gen.sv
/*
 Common line driver test pattern generator: Manchester data with end of
 packet or link pulses, each followed by a gap, or a continuous tone.
 Assumes select and gap are steady while a sequence runs.
*/
`timescale 1ns/1ps
module plt_line_gen
	import plt_pkg::*;
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	plt_line_if.gen lif
);
	plt_state_t state_reg, state_next;
	logic [11:0] cnt_reg, cnt_next;
	logic [6:0] bits_reg, bits_next;
	logic [6:0] lfsr_reg, lfsr_next;
	logic ph_reg, ph_next;
	logic level_reg, level_next;
	logic active_reg, active_next;
	logic done_reg, done_next;

	// Sequence stepping
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		bits_next = bits_reg;
		lfsr_next = lfsr_reg;
		ph_next = ph_reg;
		level_next = level_reg;
		active_next = active_reg;
		done_next = 1'b0;
		if (!lif.enable)
		begin
			state_next = ST_IDLE;
			level_next = 1'b0;
			active_next = 1'b0;
		end
		else if (state_reg != ST_IDLE && cnt_reg != 12'h000)
			cnt_next = cnt_reg - 12'h001;
		else
		begin
			cnt_next = HALF_CYC - 12'h001;
			case (state_reg)
				ST_IDLE:
				begin
					active_next = 1'b1;
					level_next = 1'b1;
					ph_next = 1'b0;
					if (lif.select == PAT_TONE)
						state_next = ST_TONE;
					else if (lif.select == PAT_NLP)
					begin
						state_next = ST_NLP;
						cnt_next = NLP_CYC - 12'h001;
					end
					else
					begin
						state_next = ST_DATA;
						bits_next = DATA_BITS - 7'h01;
						level_next = ~lfsr_reg[0];
					end
				end
				ST_DATA:
				begin
					ph_next = ~ph_reg;
					if (!ph_reg)
						level_next = lfsr_reg[0];
					else if (bits_reg == 7'h00)
					begin
						state_next = ST_EOP;
						level_next = 1'b1;
						bits_next = (lif.select == PAT_END_ONE) ? END_ONE_HALVES - 7'h01 : END_ZERO_HALVES - 7'h01;
					end
					else
					begin
						lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
						level_next = ~lfsr_next[0];
						bits_next = bits_reg - 7'h01;
					end
				end
				ST_EOP:
				begin
					if (bits_reg == 7'h00)
					begin
						state_next = ST_GAP;
						level_next = 1'b0;
						active_next = 1'b0;
						cnt_next = (lif.gap_long ? GAP15_CYC : GAP10_CYC) - 12'h001;
					end
					else
						bits_next = bits_reg - 7'h01;
				end
				ST_NLP:
				begin
					state_next = ST_GAP;
					level_next = 1'b0;
					active_next = 1'b0;
					cnt_next = (lif.gap_long ? GAP15_CYC : GAP10_CYC) - 12'h001;
				end
				ST_GAP:
				begin
					state_next = ST_IDLE;
					done_next = 1'b1;
				end
				ST_TONE:
				begin
					if (lif.select != PAT_TONE)
						state_next = ST_IDLE;
					else
						level_next = ~level_reg;
				end
				default:
					state_next = ST_IDLE;
			endcase
		end
	end

	// Generator registers
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 12'h000;
			bits_reg <= 7'h00;
			lfsr_reg <= LFSR_SEED;
			ph_reg <= 1'b0;
			level_reg <= 1'b0;
			active_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bits_reg <= bits_next;
			lfsr_reg <= lfsr_next;
			ph_reg <= ph_next;
			level_reg <= level_next;
			active_reg <= active_next;
			done_reg <= done_next;
		end
	end

	assign lif.tx_level = level_reg;
	assign lif.tx_active = active_reg;
	assign lif.seq_done = done_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	a_pattern_off: assert property (!lif.enable |=> !active_reg && !level_reg)
		else $error("pattern driven while disabled");
	a_gap_length: assert property (lif.enable && state_next == ST_GAP && state_reg != ST_GAP
		|=> cnt_reg == ($past(lif.gap_long) ? GAP15_CYC - 12'h001 : GAP10_CYC - 12'h001))
		else $error("wrong gap length loaded");
	a_select_path: assert property (lif.enable && state_reg == ST_IDLE && lif.select == PAT_NLP
		|=> state_reg == ST_NLP && active_reg)
		else $error("link pulse select not taken");
	a_tone_toggle: assert property (lif.enable && state_reg == ST_TONE && cnt_reg == 12'h000
		&& lif.select == PAT_TONE |=> level_reg != $past(level_reg))
		else $error("tone did not toggle");
endmodule

// file: rtl/plt_selftest_ext.sv
/*
 Self-test extension and line test register block behind an AHB-Lite slave:
 errored nibble counter, continuous self-test flag, line pattern controls,
 jabber disable and a sticky interrupt.
 Assumes single-word AHB-Lite transfers and synchronous inputs on clock_i.
*/
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module plt_selftest_ext
	import plt_pkg::*;
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic bist_enable_i,
	input wire logic bist_restart_i,
	input wire logic nibble_valid_i,
	input wire logic nibble_error_i,
	output logic selftest_continuous_o,
	output logic jabber_off_o,
	output logic line_level_o,
	output logic line_active_o,
	output logic irq_o
);
	plt_line_if lif ();

	logic take;
	logic dp_wr_reg, dp_wr_next;
	logic [7:0] dp_idx_reg, dp_idx_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ready_reg;
	logic resp_reg;
	logic cont_reg, cont_next;
	logic paten_reg, paten_next;
	logic gap_reg, gap_next;
	logic [1:0] sel_reg, sel_next;
	logic jab_reg, jab_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [NEV-1:0] stat_reg, stat_next;
	logic [NEV-1:0] mask_reg, mask_next;
	logic [NEV-1:0] ev;
	logic cnt_ev;
	logic contout_reg, contout_next;
	logic irq_reg, irq_next;

	// Register index match on word address
	function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] want);
		reg_hit = (idx == want);
	endfunction

	// Address phase accepted
	assign take = hsel_i & htrans_i[1] & hready_i;

	// Data phase bookkeeping
	always_comb
	begin
		dp_wr_next = take & hwrite_i;
		dp_idx_next = take ? haddr_i[9:2] : dp_idx_reg;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			dp_wr_reg <= 1'b0;
			dp_idx_reg <= 8'h00;
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end
		else
		begin
			dp_wr_reg <= dp_wr_next;
			dp_idx_reg <= dp_idx_next;
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end
	end

	// Error counter events
	assign cnt_ev = bist_enable_i & nibble_valid_i & nibble_error_i;

	// Control fields and errored nibble count
	always_comb
	begin
		cont_next = cont_reg;
		paten_next = paten_reg;
		gap_next = gap_reg;
		sel_next = sel_reg;
		jab_next = jab_reg;
		mask_next = mask_reg;
		cnt_next = cnt_reg;
		if (dp_wr_reg && reg_hit(dp_idx_reg, REG_EXT_IDX))
		begin
			// Reserved bits and the count field are not stored
			cont_next = hwdata_i[F_CONT];
			paten_next = hwdata_i[F_PATEN];
			gap_next = hwdata_i[F_GAP];
			sel_next = hwdata_i[F_SEL_LSB +: 2];
		end
		if (dp_wr_reg && reg_hit(dp_idx_reg, REG_TENMB_IDX))
			jab_next = hwdata_i[F_JAB];
		if (dp_wr_reg && reg_hit(dp_idx_reg, REG_IRQ_MASK_IDX))
			mask_next = hwdata_i[NEV-1:0];
		if (bist_restart_i)
			cnt_next = 8'h00;
		else if (cnt_ev && cnt_reg != CNT_MAX)
			cnt_next = cnt_reg + 8'h01;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cont_reg <= EXT_RESET[F_CONT];
			paten_reg <= EXT_RESET[F_PATEN];
			gap_reg <= EXT_RESET[F_GAP];
			sel_reg <= EXT_RESET[F_SEL_LSB +: 2];
			jab_reg <= 1'b0;
			mask_reg <= IRQ_RESET;
			cnt_reg <= EXT_RESET[F_CNT_LSB +: 8];
		end
		else
		begin
			cont_reg <= cont_next;
			paten_reg <= paten_next;
			gap_reg <= gap_next;
			sel_reg <= sel_next;
			jab_reg <= jab_next;
			mask_reg <= mask_next;
			cnt_reg <= cnt_next;
		end
	end

	// Interrupt events
	assign ev[EV_ERR] = cnt_ev & ~bist_restart_i;
	assign ev[EV_SAT] = cnt_ev & ~bist_restart_i & (cnt_reg == CNT_MAX - 8'h01);
	assign ev[EV_SEQ] = lif.seq_done;

	// Sticky status, write one to clear, set wins
	always_comb
	begin
		for (int i = 0; i < NEV; i++)
		begin
			stat_next[i] = ev[i] | (stat_reg[i] &
				~(dp_wr_reg & reg_hit(dp_idx_reg, REG_IRQ_STAT_IDX) & hwdata_i[i]));
		end
		irq_next = |(stat_next & mask_next);
		contout_next = bist_enable_i & cont_next;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stat_reg <= IRQ_RESET;
			irq_reg <= 1'b0;
			contout_reg <= 1'b0;
		end
		else
		begin
			stat_reg <= stat_next;
			irq_reg <= irq_next;
			contout_reg <= contout_next;
		end
	end

	// Read data from next values so a read right after a write sees it
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (take && !hwrite_i)
		begin
			if (reg_hit(haddr_i[9:2], REG_EXT_IDX))
			begin
				rdata_next[F_CNT_LSB +: 8] = cnt_next;
				rdata_next[F_CONT] = cont_next;
				rdata_next[F_PATEN] = paten_next;
				rdata_next[F_GAP] = gap_next;
				rdata_next[F_SEL_LSB +: 2] = sel_next;
			end
			else if (reg_hit(haddr_i[9:2], REG_TENMB_IDX))
				rdata_next[F_JAB] = jab_next;
			else if (reg_hit(haddr_i[9:2], REG_IRQ_STAT_IDX))
				rdata_next[NEV-1:0] = stat_next;
			else if (reg_hit(haddr_i[9:2], REG_IRQ_MASK_IDX))
				rdata_next[NEV-1:0] = mask_next;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= rdata_next;
	end

	// Pattern generator controls
	assign lif.enable = paten_reg;
	assign lif.select = sel_reg;
	assign lif.gap_long = gap_reg;

	plt_line_gen u_gen (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.lif(lif.gen)
	);

	// Outputs
	assign hrdata_o = rdata_reg;
	assign hreadyout_o = ready_reg;
	assign hresp_o = resp_reg; // Always OKAY
	assign selftest_continuous_o = contout_reg;
	assign jabber_off_o = jab_reg;
	assign line_level_o = lif.tx_level;
	assign line_active_o = lif.tx_active;
	assign irq_o = irq_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	sequence ext_read_addr;
		take && !hwrite_i && haddr_i[9:2] == REG_EXT_IDX && !bist_restart_i && !cnt_ev;
	endsequence

	sequence ext_read_data;
		hrdata_o[15:8] == cnt_reg;
	endsequence

	a_cnt_increment: assert property (cnt_ev && !bist_restart_i && cnt_reg != CNT_MAX
		|=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("errored nibble not counted");
	a_cnt_restart: assert property (bist_restart_i |=> cnt_reg == 8'h00)
		else $error("count not cleared on restart");
	a_cnt_saturate: assert property (cnt_reg == CNT_MAX && !bist_restart_i |=> cnt_reg == CNT_MAX)
		else $error("count wrapped");
	a_cont_follow: assert property (bist_enable_i && cont_reg && !dp_wr_reg
		|=> selftest_continuous_o)
		else $error("continuous mode not asserted");
	a_cont_gate: assert property (!bist_enable_i |=> !selftest_continuous_o)
		else $error("continuous mode without self-test enable");
	a_jabber_write: assert property (dp_wr_reg && dp_idx_reg == REG_TENMB_IDX
		|=> jabber_off_o == $past(hwdata_i[F_JAB]))
		else $error("jabber disable not written");
	a_read_quiet: assert property (ext_read_addr |=> ext_read_data ##0 $stable(cnt_reg))
		else $error("read changed or misreported count");
	a_irq_level: assert property (irq_o == |(stat_reg & mask_reg))
		else $error("interrupt level mismatch");
	a_sticky_set: assert property (ev[EV_ERR] |=> stat_reg[EV_ERR] ##1 stat_reg[EV_ERR] || $past(dp_wr_reg))
		else $error("status bit lost");

	// Steps of bus writes, reads and pattern shutdown
	sequence ext_write_data;
		dp_wr_reg && dp_idx_reg == REG_EXT_IDX;
	endsequence

	sequence ext_fields_loaded;
		cont_reg == $past(hwdata_i[F_CONT]) && paten_reg == $past(hwdata_i[F_PATEN])
			&& gap_reg == $past(hwdata_i[F_GAP]) && sel_reg == $past(hwdata_i[F_SEL_LSB +: 2]);
	endsequence

	sequence pattern_turned_off;
		paten_reg ##1 !paten_reg;
	endsequence

	sequence any_read_addr;
		take && !hwrite_i;
	endsequence

	sequence seq_status_clear;
		dp_wr_reg && dp_idx_reg == REG_IRQ_STAT_IDX && hwdata_i[EV_SEQ] && !ev[EV_SEQ];
	endsequence

	// Count moves only by counting or a restart
	a_cnt_hold: assert property (!cnt_ev && !bist_restart_i |=> $stable(cnt_reg))
		else $error("count changed without an event");
	a_cnt_off: assert property (!bist_enable_i && !bist_restart_i |=> $stable(cnt_reg))
		else $error("count moved while self-test off");
	a_cnt_readonly: assert property (ext_write_data ##0 (!bist_restart_i && !cnt_ev) |=> $stable(cnt_reg))
		else $error("count field took a bus write");

	// Extension fields take the written value and hold otherwise
	a_ext_write: assert property (ext_write_data |=> ext_fields_loaded)
		else $error("extension fields not written");
	a_ext_hold: assert property (!(dp_wr_reg && dp_idx_reg == REG_EXT_IDX)
		|=> $stable(paten_reg) && $stable(sel_reg) && $stable(gap_reg))
		else $error("extension fields changed without a write");
	a_cont_exact: assert property (1'b1 |=> selftest_continuous_o == ($past(bist_enable_i) && cont_reg))
		else $error("continuous output does not follow enable and bit");
	a_tenmb_hold: assert property (!(dp_wr_reg && dp_idx_reg == REG_TENMB_IDX) |=> $stable(jabber_off_o))
		else $error("jabber disable changed without a write");

	// Pattern stops and the line rests low
	a_pattern_stop: assert property (pattern_turned_off |=> !line_active_o && !line_level_o)
		else $error("pattern kept running after disable");
	a_level_idle: assert property (!line_active_o |-> !line_level_o)
		else $error("line level high while driver idle");

	// Read data: reserved bits zero, nothing outside a data phase
	a_read_reserved: assert property (any_read_addr |=> hrdata_o[31:16] == 16'h0000
		&& hrdata_o[7:6] == 2'h0 && !hrdata_o[3])
		else $error("reserved read bits not zero");
	a_read_idle: assert property (!(take && !hwrite_i) |=> hrdata_o == 32'h0000_0000)
		else $error("read data outside a data phase");
	a_tenmb_read: assert property (any_read_addr ##0 haddr_i[9:2] == REG_TENMB_IDX
		|=> hrdata_o[F_JAB] == jabber_off_o)
		else $error("jabber disable read mismatch");

	// Bus always ready with an okay response
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus stalled or error response");

	// Events reach their status bits; write one clears
	a_err_event: assert property (ev[EV_ERR] |=> stat_reg[EV_ERR])
		else $error("errored nibble event lost");
	a_sat_event: assert property (ev[EV_SAT] |=> stat_reg[EV_SAT] && cnt_reg == CNT_MAX)
		else $error("saturation event lost");
	a_seq_event: assert property (lif.seq_done |=> stat_reg[EV_SEQ])
		else $error("sequence done event lost");
	a_stat_clear: assert property (seq_status_clear |=> !stat_reg[EV_SEQ])
		else $error("status bit not cleared by write");
	a_mask_write: assert property (dp_wr_reg && dp_idx_reg == REG_IRQ_MASK_IDX
		|=> mask_reg == $past(hwdata_i[NEV-1:0]))
		else $error("mask not written");
	a_irq_unmasked: assert property (stat_reg[EV_SEQ] && mask_reg[EV_SEQ] |-> irq_o)
		else $error("unmasked status without interrupt");
endmodule

// file: verif/test_packet_bist_ext_and_line_test_patterns.sv
/*
 Self-checking bench for plt_selftest_ext: register access, errored nibble
 counter, interrupt, jabber disable and line pattern timing.
 Assumes a zero-wait AHB-Lite slave with a one-cycle data phase.
*/
`timescale 1ns/1ps
module test_packet_bist_ext_and_line_test_patterns
	import plt_pkg::*;
;
	localparam int LIMIT = 80000;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic bist_en = 1'b0;
	logic restart = 1'b0;
	logic nib_v = 1'b0;
	logic nib_e = 1'b0;
	logic cont;
	logic jab;
	logic level;
	logic active;
	logic irq;
	logic rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;

	plt_selftest_ext i_dut (.clock_i(clock), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .bist_enable_i(bist_en),
		.bist_restart_i(restart), .nibble_valid_i(nib_v), .nibble_error_i(nib_e),
		.selftest_continuous_o(cont), .jabber_off_o(jab), .line_level_o(level),
		.line_active_o(active), .irq_o(irq));

	// Clock and cycle ceiling
	initial
	begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			fails++;
			give_verdict();
		end
	end

	function automatic logic [31:0] adr(input logic [7:0] idx);
		return {22'h0, idx, 2'h0};
	endfunction

	task give_verdict;
		begin
			$display("Checks %0d, mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	task compare_word(input string what, input logic [31:0] e, input logic [31:0] g);
		begin
			samples_checked++;
			if (g !== e)
			begin
				fails++;
				$display("ERROR %s expected %h seen %h", what, e, g);
			end
		end
	endtask

	task check_bit(input string what, input logic e, input logic g);
		begin
			samples_checked++;
			if (g !== e)
			begin
				fails++;
				$display("ERROR %s expected %b seen %b", what, e, g);
			end
		end
	endtask

	task check_near(input string what, input int e, input int g, input int tol);
		begin
			samples_checked++;
			if (g < e - tol || g > e + tol)
			begin
				fails++;
				$display("ERROR %s expected %0d seen %0d", what, e, g);
			end
		end
	endtask

	// Bus cycles: address phase held until hready, then data phase
	task ahb_cycle(input logic [31:0] a, input logic wr, input logic [31:0] d);
		begin
			@(posedge clock);
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= wr;
			hsize <= 3'h2;
			do @(posedge clock); while (hreadyout !== 1'b1);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			do @(posedge clock); while (hreadyout !== 1'b1);
		end
	endtask
	task ahb_write(input logic [31:0] a, input logic [31:0] d);
		ahb_cycle(a, 1'b1, d);
	endtask
	task ahb_read(input logic [31:0] a, input logic [31:0] e);
		begin
			exp_q.push_back(e);
			ahb_cycle(a, 1'b0, 32'h0);
		end
	endtask

	// Read data watcher takes the oldest note at each read data phase
	always @(posedge clock)
		rd_pend <= hsel & htrans[1] & ~hwrite & hreadyout;
	always @(negedge clock)
	begin
		if (rd_pend)
		begin
			if (exp_q.size() == 0)
				compare_word("unexpected read", 32'h0, 32'hFFFFFFFF);
			else
				compare_word("hrdata_o", exp_q.pop_front(), hrdata);
		end
	end

	// Cycles on negedges until line_active_o reaches v
	task wait_act(input logic v, input int lim, output int n);
		begin
			n = 0;
			while (active !== v && n < lim)
			begin
				@(negedge clock);
				n++;
			end
		end
	endtask

	task nibbles(input int num, input logic rnd, inout int exp);
		logic v;
		logic e;
		begin
			repeat (num)
			begin
				@(posedge clock);
				v = rnd ? 1'($urandom) : 1'b1;
				e = rnd ? 1'($urandom) : 1'b1;
				nib_v <= v;
				nib_e <= e;
				if (bist_en && v && e && exp < 255)
					exp++;
			end
			@(posedge clock);
			nib_v <= 1'b0;
			nib_e <= 1'b0;
		end
	endtask

	task run_pat(input logic [1:0] sel, input logic gap);
		int n;
		int act;
		int idle;
		int e;
		begin
			ahb_write(adr(REG_EXT_IDX), 32'h10 | (32'(gap) << 2) | 32'(sel));
			wait_act(1'b1, 100, n);
			check_near("pattern start", 2, n, 2);
			wait_act(1'b0, 5000, act);
			wait_act(1'b1, 5000, idle);
			e = (sel == 2'h0) ? END_ZERO_HALVES * HALF_CYC : END_ONE_HALVES * HALF_CYC;
			e = (sel == 2'h2) ? NLP_CYC : DATA_BITS * 2 * HALF_CYC + e;
			check_near("sequence length", e, act, 2);
			check_near("gap length", gap ? GAP15_CYC : GAP10_CYC, idle, 2);
			check_bit("irq_o on sequence done", 1'b1, irq);
			ahb_write(adr(REG_EXT_IDX), 32'h0);
			@(negedge clock);
			@(negedge clock);
			check_bit("line_active_o off", 1'b0, active);
			check_bit("line_level_o off", 1'b0, level);
			wait_act(1'b1, 200, n);
			check_near("quiet while disabled", 200, n, 0);
			ahb_read(adr(REG_IRQ_STAT_IDX), 32'h4);
			ahb_write(adr(REG_IRQ_STAT_IDX), 32'h4);
		end
	endtask

	// Main sequence
	initial
	begin
		int cnt;
		int n;
		int tog;
		int brk;
		logic prev;
		cnt = 0;
		void'($urandom(28630));
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		ahb_read(adr(REG_EXT_IDX), {16'h0, EXT_RESET});
		ahb_read(adr(REG_TENMB_IDX), 32'h0);
		ahb_read(32'h40, 32'h0);
		ahb_write(32'h40, 32'hFFFFFFFF);
		ahb_read(32'h40, 32'h0);
		check_bit("hresp_o", 1'b0, hresp);
		// Jabber disable bit both ways
		ahb_write(adr(REG_TENMB_IDX), 32'h1);
		ahb_read(adr(REG_TENMB_IDX), 32'h1);
		check_bit("jabber_off_o set", 1'b1, jab);
		// Continuous mode follows the self-test enable
		ahb_write(adr(REG_EXT_IDX), 32'h20);
		repeat (2) @(negedge clock);
		check_bit("continuous without enable", 1'b0, cont);
		@(posedge clock);
		bist_en <= 1'b1;
		repeat (2) @(negedge clock);
		check_bit("continuous with enable", 1'b1, cont);
		ahb_write(adr(REG_TENMB_IDX), 32'h0);
		ahb_read(adr(REG_TENMB_IDX), 32'h0);
		check_bit("jabber_off_o clear", 1'b0, jab);
		ahb_write(adr(REG_EXT_IDX), 32'h0);
		// Errors ignored while self-test is off, counted while on
		@(posedge clock);
		bist_en <= 1'b0;
		nibbles(30, 1'b1, cnt);
		ahb_read(adr(REG_EXT_IDX), 32'h0);
		@(posedge clock);
		bist_en <= 1'b1;
		nibbles(60, 1'b1, cnt);
		ahb_read(adr(REG_EXT_IDX), 32'(cnt) << 8);
		ahb_read(adr(REG_EXT_IDX), 32'(cnt) << 8);
		// Saturation and the interrupt on reaching the top
		ahb_write(adr(REG_IRQ_MASK_IDX), 32'h2);
		nibbles(300, 1'b0, cnt);
		ahb_read(adr(REG_EXT_IDX), {16'h0, CNT_MAX, 8'h0});
		check_bit("irq_o saturated", 1'b1, irq);
		ahb_read(adr(REG_IRQ_STAT_IDX), 32'h3);
		ahb_write(adr(REG_IRQ_MASK_IDX), 32'h0);
		@(negedge clock);
		check_bit("irq_o masked", 1'b0, irq);
		// Restart clears the count
		@(posedge clock);
		restart <= 1'b1;
		@(posedge clock);
		restart <= 1'b0;
		ahb_read(adr(REG_EXT_IDX), 32'h0);
		ahb_write(adr(REG_IRQ_STAT_IDX), 32'h7);
		ahb_read(adr(REG_IRQ_STAT_IDX), 32'h0);
		// Each data and link-pulse pattern with both gaps
		ahb_write(adr(REG_IRQ_MASK_IDX), 32'h4);
		for (int i = 0; i < 3; i++)
		begin
			run_pat(2'(i), 1'b0);
			run_pat(2'(i), 1'b1);
		end
		// Tone: unbroken, toggling every half period
		ahb_write(adr(REG_EXT_IDX), 32'h13);
		wait_act(1'b1, 100, n);
		prev = level;
		tog = 0;
		brk = 0;
		repeat (130)
		begin
			@(negedge clock);
			if (level !== prev)
				tog++;
			if (active !== 1'b1)
				brk++;
			prev = level;
		end
		check_near("tone toggles", 10, tog, 1);
		check_near("tone breaks", 0, brk, 0);
		ahb_write(adr(REG_EXT_IDX), 32'h0);
		repeat (2) @(negedge clock);
		check_bit("tone off", 1'b0, active);
		give_verdict();
	end
endmodule
